// ### design/line_term_regs.v
// ahb-lite register block: loop voltage status, ac termination control,
// dc termination voltage adjust, interrupt status and mask.
// assumes a single ahb-lite master, word transfers only, one clock hclk.
//
// Notes on behaviour
// - loop voltage reads as an eight-bit read-only value, one volt per step.
// - loop voltage is refreshed continuously whether on-hook or off-hook.
// - bit 7 of the loop voltage gives the tip/ring polarity.
// - a polarity reversal shows as a toggle of bit 7 and raises an event.
// - loop voltage is a two's complement signed number.
// - with no line attached the loop voltage reads all zeros.
// - ac termination bit 5 takes writes of either value with no effect.
// - ac termination bit 4 enables double full scale, reset 0.
// - ac termination bits 3:0 pick the impedance, 0000 is 600 ohm, 1111 global.
// - dc termination bits 7:6 hold the voltage adjust, 11 is highest.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
`include "line_term_defs.vh"
`default_nettype none

module line_term_regs #(
    parameter WIDTH = 8                          // register data width
) (
    input  wire             hclk,                // bus clock, 40 MHz
    input  wire             hresetn,             // async reset, active low
    input  wire             hsel,                // slave select
    input  wire [31:0]      haddr,               // byte address
    input  wire [1:0]       htrans,              // transfer type
    input  wire             hwrite,              // write when high
    input  wire [2:0]       hsize,               // transfer size
    input  wire             hready,              // bus ready in
    input  wire [31:0]      hwdata,              // write data
    output reg  [31:0]      hrdata,              // read data
    output reg              hreadyout,           // slave ready
    output reg              hresp,               // always okay
    input  wire [WIDTH-1:0] loop_voltage_in,     // measured voltage, async
    input  wire             line_present_in,     // line attached, async
    output reg              double_full_scale,   // 2x full scale enable
    output reg  [3:0]       ac_impedance_select, // off-hook ac termination
    output reg  [1:0]       tip_ring_voltage_adjust, // dct pin voltage code
    output reg              irq                  // level interrupt
);

    // ==========================================================
    // register map, byte address = index * 4, data in bits 7:0
    //   0x74 line voltage, read only, signed volts, zero without line
    //   0x78 ac termination: 7:6 read zero, 5 spare, 4 double full scale,
    //        3:0 impedance code
    //   0x68 dc termination: 7:6 voltage adjust, 5:0 plain storage
    //   0x80 event status, sticky, the bits returned by a read are cleared
    //   0x84 event mask, same layout; irq follows status & mask != 0 one cycle later
    //   any other index reads zero and ignores writes
    // zero wait states: hreadyout never drops and hresp is always okay

    // ==========================================================
    // measurement capture
    wire [WIDTH-1:0] line_voltage_value;
    wire             present;

    voltage_sample #(
        .WIDTH (WIDTH)
    ) u_sample (
        .hclk            (hclk),
        .hresetn         (hresetn),
        .meas_in         (loop_voltage_in),
        .line_present_in (line_present_in),
        .value           (line_voltage_value),
        .present         (present)
    );

    // ==========================================================
    // address phase capture
    reg        dp_valid;
    reg        dp_write;
    reg [7:0]  dp_index;
    wire       ap_take = hsel & hready & htrans[1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_index <= 8'h00;
        end else begin
            dp_valid <= ap_take;
            if (ap_take) begin
                dp_write <= hwrite;
                dp_index <= haddr[9:2];
            end
        end
    end

    wire wr_stb = dp_valid & dp_write;
    wire rd_stb = dp_valid & ~dp_write;

    // per-register write strobes of the data phase, used by read forwarding
    wire wr_ac   = wr_stb & (dp_index == `IDX_AC_TERM_CONTROL);
    wire wr_dc   = wr_stb & (dp_index == `IDX_DC_TERM_CONTROL);
    wire wr_mask = wr_stb & (dp_index == `IDX_IRQ_MASK);

    // ==========================================================
    // control registers
    reg       ac_spare;     // bit 5, stored but drives nothing
    reg [5:0] dc_other;     // remaining dc termination bits, plain storage
    reg [`IRQ_BITS-1:0] irq_mask;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            double_full_scale       <= 1'b0;
            ac_spare                <= 1'b0;
            ac_impedance_select     <= `AC_IMPEDANCE_SELECT_600_OHM;
            tip_ring_voltage_adjust <= 2'h0;
            dc_other                <= 6'h00;
            irq_mask                <= `RST_IRQ;
        end else if (wr_stb) begin
            case (dp_index)
                `IDX_AC_TERM_CONTROL: begin
                    // bits 7:6 dropped on write
                    ac_spare            <= hwdata[`POS_AC_RESERVED];
                    double_full_scale   <= hwdata[`POS_DOUBLE_FULL_SCALE];
                    ac_impedance_select <= hwdata[3:0];
                end
                `IDX_DC_TERM_CONTROL: begin
                    tip_ring_voltage_adjust <= hwdata[`POS_VADJ_HI:`POS_VADJ_LO];
                    dc_other                <= hwdata[5:0];
                end
                `IDX_IRQ_MASK: begin
                    irq_mask <= hwdata[`IRQ_BITS-1:0];
                end
                default: begin
                    irq_mask <= irq_mask;
                end
            endcase
        end
    end

    // ==========================================================
    // events: polarity toggle, value change, line lost
    reg              prev_polarity;
    reg [WIDTH-1:0]  prev_value;
    reg              prev_present;
    wire [`IRQ_BITS-1:0] events;

    assign events[`IRQ_REVERSAL] = present & prev_present &
        (line_voltage_value[WIDTH-1] != prev_polarity);
    assign events[`IRQ_VOLTAGE_CHANGE] = (line_voltage_value != prev_value);
    assign events[`IRQ_NO_LINE] = prev_present & ~present;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_polarity <= 1'b0;
            prev_value    <= `RST_LINE_VOLTAGE;
            prev_present  <= 1'b0;
        end else begin
            prev_polarity <= line_voltage_value[WIDTH-1];
            prev_value    <= line_voltage_value;
            prev_present  <= present;
        end
    end

    // ==========================================================
    // sticky status, cleared by read; a new event wins over the clear
    reg [`IRQ_BITS-1:0] irq_status;
    wire clr_status = rd_stb & (dp_index == `IDX_IRQ_STATUS);

    // only bits the read returned are cleared: hrdata still holds them in
    // the data phase, so an event that lands between the address phase and
    // the clear stays set for the next read instead of being lost
    genvar b;
    generate
        for (b = 0; b < `IRQ_BITS; b = b + 1) begin : g_status
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn)
                    irq_status[b] <= `RST_IRQ_BIT;
                else if (events[b])
                    irq_status[b] <= 1'b1;       // set beats clear
                else if (clr_status & hrdata[b])
                    irq_status[b] <= 1'b0;
            end
        end
    endgenerate

    // registered so the output comes straight from a flip-flop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end

    // ==========================================================
    // read mux, decoded in the address phase so data is ready in the data phase
    reg [31:0] next_hrdata;

    // a write still in its data phase has not reached its register yet, so a
    // read issued right behind it takes the new value straight from hwdata
    wire [5:0]           ac_now   = wr_ac ? hwdata[5:0] :
                                    {ac_spare, double_full_scale, ac_impedance_select};
    wire [7:0]           dc_now   = wr_dc ? hwdata[7:0] :
                                    {tip_ring_voltage_adjust, dc_other};
    wire [`IRQ_BITS-1:0] mask_now = wr_mask ? hwdata[`IRQ_BITS-1:0] : irq_mask;

    // a status read right behind another must not report bits being cleared
    wire [`IRQ_BITS-1:0] status_now = clr_status ?
                                      (irq_status & ~hrdata[`IRQ_BITS-1:0]) : irq_status;

    always @* begin
        next_hrdata = 32'h00000000;
        case (haddr[9:2])
            `IDX_LINE_VOLTAGE_STATUS:
                // signed two's complement volts, one per lsb
                next_hrdata[WIDTH-1:0] = line_voltage_value;
            `IDX_AC_TERM_CONTROL:
                // bits 7:6 always zero
                next_hrdata[7:0] = {2'b00, ac_now};
            `IDX_DC_TERM_CONTROL:
                next_hrdata[7:0] = dc_now;
            `IDX_IRQ_STATUS:
                next_hrdata[`IRQ_BITS-1:0] = status_now;
            `IDX_IRQ_MASK:
                next_hrdata[`IRQ_BITS-1:0] = mask_now;
            default:
                next_hrdata = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (ap_take & ~hwrite)
                hrdata <= next_hrdata;
        end
    end

endmodule // line_term_regs

`default_nettype wire

// ### design/voltage_sample.v
// samples the measured loop voltage from the analog side into the hclk domain.
// assumes the converter word changes far slower than hclk; adjacent samples
// that disagree are rejected so a torn multi-bit capture never reaches software.
`timescale 1ns/100ps
`include "line_term_defs.vh"
`default_nettype none

module voltage_sample #(
    parameter WIDTH = 8                      // measurement width
) (
    input  wire             hclk,            // bus clock
    input  wire             hresetn,         // async reset, active low
    input  wire [WIDTH-1:0] meas_in,         // raw measurement, async
    input  wire             line_present_in, // line attached, async
    output reg  [WIDTH-1:0] value,           // settled voltage word
    output reg              present          // settled line presence
);

    reg [WIDTH-1:0] meas_s1;
    reg [WIDTH-1:0] meas_s2;
    reg [WIDTH-1:0] meas_s3;
    reg             pres_s1;
    reg             pres_s2;

    // ==========================================================
    // two-stage synchronisers, first stage read only by the second
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meas_s1 <= {WIDTH{1'b0}};
            meas_s2 <= {WIDTH{1'b0}};
            meas_s3 <= {WIDTH{1'b0}};
            pres_s1 <= 1'b0;
            pres_s2 <= 1'b0;
        end else begin
            meas_s1 <= meas_in;
            meas_s2 <= meas_s1;
            meas_s3 <= meas_s2;
            pres_s1 <= line_present_in;
            pres_s2 <= pres_s1;
        end
    end

    // ==========================================================
    // accept word only once two samples agree; no line forces zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value   <= `RST_LINE_VOLTAGE;
            present <= 1'b0;
        end else begin
            present <= pres_s2;
            if (!pres_s2)
                value <= `NO_LINE_VALUE;
            else if (meas_s2 == meas_s3)
                value <= meas_s2;
        end
    end

endmodule // voltage_sample

`default_nettype wire

// ### inc/line_term_defs.vh
// register offsets, field positions, reset values and codes for the
// line voltage / ac termination register block.
// assumes inclusion by bare name from design files.
`ifndef LINE_TERM_DEFS_VH
`define LINE_TERM_DEFS_VH

// ==========================================================
// register indices (byte address = index * 4)
`define IDX_LINE_VOLTAGE_STATUS   8'h1D
`define IDX_AC_TERM_CONTROL       8'h1E
`define IDX_IRQ_STATUS            8'h20
`define IDX_IRQ_MASK              8'h21
`define IDX_DC_TERM_CONTROL       8'h1A

// ==========================================================
// field positions
`define POS_POLARITY              7
`define POS_DOUBLE_FULL_SCALE     4
`define POS_AC_RESERVED           5
`define POS_VADJ_HI               7
`define POS_VADJ_LO               6
`define IRQ_REVERSAL              0
`define IRQ_VOLTAGE_CHANGE        1
`define IRQ_NO_LINE               2
`define IRQ_BITS                  3

// ==========================================================
// reset values and codes
`define RST_LINE_VOLTAGE          8'h00
`define RST_AC_TERM               6'h00
`define RST_DC_TERM               8'h00
`define RST_IRQ                   3'h0
`define RST_IRQ_BIT               1'b0
`define AC_IMPEDANCE_SELECT_600_OHM              4'h0
`define AC_IMPEDANCE_SELECT_GLOBAL               4'hF
`define NO_LINE_VALUE             8'h00

`endif

// ### sim/line_term_regs_sva.sv
// checker for the line termination register block
// assumes it is bound onto line_term_regs, one clock hclk
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bus tracking and assertions
module line_term_regs_sva #(
    parameter WIDTH = 8                              // register data width
) (
    input wire logic             hclk, hresetn,      // clock, reset
    input wire logic             hsel, hwrite, hready, // bus control
    input wire logic [31:0]      haddr, hwdata, hrdata, // bus data
    input wire logic [1:0]       htrans,             // transfer type
    input wire logic [2:0]       hsize,              // transfer size
    input wire logic             hreadyout, hresp,   // slave answer
    input wire logic [WIDTH-1:0] loop_voltage_in,    // measured voltage
    input wire logic             line_present_in,    // line attached
    input wire logic             double_full_scale, irq, // control, interrupt
    input wire logic [3:0]       ac_impedance_select, // impedance code
    input wire logic [1:0]       tip_ring_voltage_adjust // voltage code
);
    logic       ph;                 // data phase under way
    logic       pw;                 // it is a write
    logic [7:0] pi;                 // register index
    logic [3:0] nl;                 // cycles without line
    logic [3:0] st;                 // cycles of steady voltage
    // counters saturate so long idle spans cannot wrap back to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph <= 1'b0;
            nl <= 4'h0;
            st <= 4'h0;
        end else begin
            ph <= hsel && hready && htrans[1];
            nl <= line_present_in ? 4'h0 : nl + {3'h0, nl != 4'hF};
            st <= ($stable(loop_voltage_in) && line_present_in) ? st + {3'h0, st != 4'hF} : 4'h0;
        end
    end
    // address phase fields held for the data phase
    always_ff @(posedge hclk) begin
        pw <= hwrite;
        pi <= haddr[9:2];
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or okay");
    chk_ac_write: assert property (ph && pw && pi == 8'h1E |=> {double_full_scale, ac_impedance_select} == $past(hwdata[4:0]))
        else $error("ac termination write not applied");
    chk_ac_hold: assert property (!(ph && pw && pi == 8'h1E) |=> $stable({double_full_scale, ac_impedance_select}))
        else $error("ac termination changed without write");
    chk_dc_write: assert property (ph && pw && pi == 8'h1A |=> tip_ring_voltage_adjust == $past(hwdata[7:6]))
        else $error("voltage adjust write not applied");
    chk_ac_read: assert property (ph && !pw && pi == 8'h1E |-> hrdata[7:0] == {2'b00, hrdata[5], double_full_scale, ac_impedance_select})
        else $error("ac termination read wrong");
    chk_upper_zero: assert property (ph && !pw |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
    chk_volt_absent: assert property (ph && !pw && pi == 8'h1D && nl == 4'hF |-> hrdata[7:0] == 8'h00)
        else $error("voltage not zero without line");
    chk_volt_value: assert property (ph && !pw && pi == 8'h1D && st == 4'hF |-> hrdata[7:0] == loop_voltage_in)
        else $error("voltage read differs from input");
    chk_irq_quiet: assert property (ph && pw && pi == 8'h21 && hwdata[2:0] == 3'h0 |=> ##1 !irq [*3])
        else $error("interrupt high with all masked");
    cover property (ph && !pw && pi == 8'h20 && hrdata[1]);
    cover property (ph && pw && pi == 8'h1E && hwdata[4]);
    cover property (ph && !pw && pi == 8'h1D && hrdata[7]);
endmodule // line_term_regs_sva

bind line_term_regs line_term_regs_sva #(.WIDTH(WIDTH)) line_term_regs_sva_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
    .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .htrans(htrans), .hsize(hsize),
    .hreadyout(hreadyout), .hresp(hresp), .loop_voltage_in(loop_voltage_in),
    .line_present_in(line_present_in), .double_full_scale(double_full_scale), .irq(irq),
    .ac_impedance_select(ac_impedance_select), .tip_ring_voltage_adjust(tip_ring_voltage_adjust));
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the line termination register block
// assumes line_term_regs on one 40 MHz clock with the checker bound
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bench top
module testbench;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, e;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0, hreadyout, hresp, irq, dfs, lp = 1'b1;
    logic [3:0]  imp;
    logic [1:0]  tva;
    logic [7:0]  lv = 8'h30;
    int          miscompares = 0, num_checks = 0, i;
    // free-running bus clock
    always #12.5 hclk = ~hclk;
    line_term_regs line_term_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .loop_voltage_in(lv), .line_present_in(lp), .double_full_scale(dfs),
        .ac_impedance_select(imp), .tip_ring_voltage_adjust(tva), .irq(irq));
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for hready, a hang ends the run
    task automatic step;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            conclude;
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        step;
        htrans <= 2'h0;
        hwdata <= d;
        step;
        q = hrdata;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(32'h78, 32'h0);
        rd_chk(32'h68, 32'h0);
        rd_chk(32'h84, 32'h0);
        // every impedance code, spare and full scale bits varied
        for (i = 0; i < 16; i++) begin
            e = {26'h0, i[0], i[1], i[3:0]};
            xfer(1'b1, 32'h78, 32'hFFFF_FFC0 | e);
            rd_chk(32'h78, e);
            chk({28'h0, imp}, {28'h0, e[3:0]});
            chk({31'h0, dfs}, {31'h0, e[4]});
        end
        xfer(1'b1, 32'h68, 32'hC0);
        rd_chk(32'h68, 32'hC0);
        chk({30'h0, tva}, 32'h3);
        xfer(1'b1, 32'h3FC, 32'hA5);
        rd_chk(32'h3FC, 32'h0);
        xfer(1'b1, 32'h74, 32'h55);
        rd_chk(32'h74, 32'h30);
        // only the power-up change 0 -> 0x30 so far, no reversal
        rd_chk(32'h80, 32'h2);
        // masked reversal: status set, no interrupt
        lv <= 8'hD8;
        repeat (16) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(32'h74, 32'hD8);
        rd_chk(32'h80, 32'h3);
        xfer(1'b1, 32'h84, 32'h7);
        lv <= 8'h30;
        repeat (16) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(32'h74, 32'h30);
        rd_chk(32'h80, 32'h3);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        lp <= 1'b0;
        repeat (16) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(32'h74, 32'h0);
        rd_chk(32'h80, 32'h6);
        xfer(1'b1, 32'h84, 32'h0);
        repeat (3) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        lp <= 1'b1;
        lv <= 8'h80;
        repeat (16) @(posedge hclk);
        rd_chk(32'h74, 32'h80);
        // reduced line side: impedance bits 3:2 and 0 written as zero
        xfer(1'b1, 32'h78, 32'h02);
        rd_chk(32'h78, 32'h02);
        chk({28'h0, imp}, 32'h2);
        conclude;
    end
endmodule // testbench
`default_nettype wire
